// File: rtc_pkg.sv
/*
 Shared constants and types of the real-time clock core: register map,
 field positions, reset values, timing counts, bus and time carriers.
 Assumes a 250 MHz system clock and byte addresses on the register bus.
*/
`default_nettype none
package rtc_pkg;
	// timing
	localparam int CLK_MHZ = 250;
	localparam int PULSE_MS = 250;
	localparam int PULSE_CYC = PULSE_MS * CLK_MHZ * 1000;
	localparam int OSC_HZ = 32768;
	localparam int I2C_MAX_KHZ = 400;
	// serial bus address, value arbitrary
	localparam logic [6:0] I2C_DEV_ADDR = 7'h52;
	// register byte offsets
	localparam logic [4:0] OFS_TIME = 5'h00;
	localparam logic [4:0] OFS_DATE = 5'h04;
	localparam logic [4:0] OFS_ALM_T = 5'h08;
	localparam logic [4:0] OFS_ALM_D = 5'h0c;
	localparam logic [4:0] OFS_CTRL = 5'h10;
	localparam logic [4:0] OFS_STAT = 5'h14;
	localparam logic [4:0] OFS_MASK = 5'h18;
	// field positions
	localparam int CTL_ALM_EN = 0;
	localparam int CTL_IM = 1;
	localparam int CTL_ACLR = 2;
	localparam int CTL_FO_LSB = 4;
	localparam int ST_ALM = 0;
	localparam int ST_SEC = 1;
	localparam logic [31:0] ALM_T_MASK = 32'h879f_bfbf;
	localparam logic [23:0] ALM_D_MASK = 24'hff_8f_9f;
	// limits and reset values
	localparam logic [5:0] SEC_MAX = 6'h3b;
	localparam logic [5:0] MIN_MAX = 6'h3b;
	localparam logic [4:0] HOUR_MAX = 5'h17;
	localparam logic [2:0] DOW_MAX = 3'h6;
	localparam logic [3:0] MONTH_MAX = 4'hc;
	localparam logic [6:0] YEAR_MAX = 7'h63;
	localparam logic [4:0] DATE_RST = 5'h01;
	localparam logic [3:0] MONTH_RST = 4'h1;

	typedef struct packed {
		logic [6:0] year;
		logic [3:0] month;
		logic [4:0] date;
		logic [2:0] dow;
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
	} rtc_time_s;

	typedef struct packed {
		logic [4:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} rtc_avs_req_s;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} rtc_avs_rsp_s;

	typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_WR, I2C_RD, I2C_RACK} rtc_i2c_e;
endpackage
`default_nettype wire

// File: rtc_sync.sv
/*
 Two-stage synchroniser for a vector of independent levels.
 Assumes each bit is a slow level; no bus coherence across bits.
*/
`timescale 1ns/100ps
`default_nettype none
module rtc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// levels from outside, levels in clock domain
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	import rtc_pkg::*;
	logic [1:0][W-1:0] s_reg, s_next;

	always_comb begin
		s_next = {s_reg[0], d};
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign q = s_reg[1];
endmodule // rtc_sync
`default_nettype wire

// File: rtc_core.sv
/*
 Real-time clock and calendar with alarm, shared alarm/frequency pin,
 a small two-wire serial read port and an Avalon-MM register slave.
 Assumes osc, scl, sda and backup inputs are asynchronous levels.
*/
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Seconds, minutes, hours, date, month, year and weekday are kept as separate counters.
// - The calendar rolls over correctly to 2099 and inserts the leap day on its own.
// - The alarm compares any enabled field with the running time and fires on a full match while the frequency-select bits are zero.
// - An alarm sets a readable status flag and may also drive the shared pin as an interrupt.
// - A repeating mode lets the alarm fire again on every later match.
// - Time is derived from the 32.768 kHz reference on the oscillator input.
// - The frequency-select control bits choose between interrupt and frequency use of the shared pin.
// - In interrupt mode the shared pin is open-drain and pulls low to report an alarm.
// - In frequency mode the shared pin pulls low open-drain following a selected crystal-derived clock.
// - In backup supply mode the serial clock is ignored and the data line is never pulled low.
// - Serial data both ways is clocked by the master's clock on an open-drain data line.
// - The serial bus runs at up to 400 kHz and the master keeps below that rate.
// - In single-event mode a match pulls the pin low and sets the flag until cleared by software or auto-clear.
// - In pulsed mode each match pulls the pin low for 250 ms and sets the flag.
module rtc_core #(
	parameter int PULSE_CYCLES = rtc_pkg::PULSE_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// register bus
	input wire rtc_pkg::rtc_avs_req_s avs_req,
	output var rtc_pkg::rtc_avs_rsp_s avs_rsp,
	output logic irq,
	// oscillator
	input wire logic osc_input_pin,
	output logic osc_output_pin,
	// serial bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// supply state and shared pin
	input wire logic backup_mode,
	output logic alarm_or_freq_out_pin_out,
	output logic alarm_or_freq_out_pin_oe
);
	import rtc_pkg::*;

	typedef struct packed {
		rtc_time_s tm;
		logic [14:0] pre;
		logic osc_d;
		logic scl_d;
		logic sda_d;
		logic tick_d;
		logic osc_out;
		logic [31:0] alm_t;
		logic [23:0] alm_d;
		logic [7:0] ctrl;
		logic [1:0] status;
		logic [1:0] mask;
		logic [25:0] pulse;
		logic pin_oe;
		logic irq;
		logic wreq;
		logic [31:0] rdata;
		rtc_i2c_e st;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic rw;
		logic [2:0] ptr;
		logic sda_oe;
	} rtc_core_s;

	rtc_core_s s_reg, s_next;
	logic [3:0] syn;
	logic osc_s, scl_s, sda_s, bkp_s;
	logic osc_edge, sec_tick, scl_rise, scl_fall, i2c_start, i2c_stop;
	logic fo_lvl, any_en, alm_hit, wr_acc, rd_acc;
	logic [3:0] fo;
	logic [7:0] rd_byte;
	logic [31:0] time_w, date_w;

	function automatic logic [4:0] days_in(input logic [3:0] m, input logic [6:0] y);
		case (m)
			4'h2: days_in = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
			4'h4, 4'h6, 4'h9, 4'hb: days_in = 5'h1e;
			default: days_in = 5'h1f;
		endcase
	endfunction

	function automatic logic fmatch(input logic en, input logic [6:0] a, input logic [6:0] c);
		fmatch = !en || (a == c);
	endfunction

	// sampling at 250 MHz leaves wide margin under a 400 kHz bus
	rtc_sync #(.W(4)) u_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.d({backup_mode, sda_in, scl_in, osc_input_pin}),
		.q(syn)
	);
	assign {bkp_s, sda_s, scl_s, osc_s} = syn;

	assign osc_edge = osc_s && !s_reg.osc_d;
	assign sec_tick = osc_edge && (s_reg.pre == 15'h7fff);
	// backup mode blinds the serial front end
	assign scl_rise = !bkp_s && scl_s && !s_reg.scl_d;
	assign scl_fall = !bkp_s && !scl_s && s_reg.scl_d;
	assign i2c_start = !bkp_s && scl_s && s_reg.scl_d && s_reg.sda_d && !sda_s;
	assign i2c_stop = !bkp_s && scl_s && s_reg.scl_d && !s_reg.sda_d && sda_s;
	assign fo = s_reg.ctrl[CTL_FO_LSB +: 4];
	assign fo_lvl = (fo == 4'h1) ? osc_s : s_reg.pre[fo - 4'h2];
	assign wr_acc = avs_req.write && !s_reg.wreq;
	assign rd_acc = avs_req.read && !s_reg.wreq;

	assign time_w = {5'h00, s_reg.tm.dow, 3'h0, s_reg.tm.hour, 2'h0, s_reg.tm.min, 2'h0, s_reg.tm.sec};
	assign date_w = {9'h000, s_reg.tm.year, 4'h0, s_reg.tm.month, 3'h0, s_reg.tm.date};

	assign any_en = s_reg.alm_t[7] | s_reg.alm_t[15] | s_reg.alm_t[23] | s_reg.alm_t[31] |
		s_reg.alm_d[7] | s_reg.alm_d[15] | s_reg.alm_d[23];
	// compare one cycle after the tick, against the freshly counted time
	assign alm_hit = s_reg.tick_d && s_reg.ctrl[CTL_ALM_EN] && (fo == 4'h0) && any_en &&
		fmatch(s_reg.alm_t[7], {1'b0, s_reg.alm_t[5:0]}, {1'b0, s_reg.tm.sec}) &&
		fmatch(s_reg.alm_t[15], {1'b0, s_reg.alm_t[13:8]}, {1'b0, s_reg.tm.min}) &&
		fmatch(s_reg.alm_t[23], {2'h0, s_reg.alm_t[20:16]}, {2'h0, s_reg.tm.hour}) &&
		fmatch(s_reg.alm_t[31], {4'h0, s_reg.alm_t[26:24]}, {4'h0, s_reg.tm.dow}) &&
		fmatch(s_reg.alm_d[7], {2'h0, s_reg.alm_d[4:0]}, {2'h0, s_reg.tm.date}) &&
		fmatch(s_reg.alm_d[15], {3'h0, s_reg.alm_d[11:8]}, {3'h0, s_reg.tm.month}) &&
		fmatch(s_reg.alm_d[23], s_reg.alm_d[22:16], s_reg.tm.year);

	always_comb begin
		case (s_reg.ptr)
			3'h0: rd_byte = {2'h0, s_reg.tm.sec};
			3'h1: rd_byte = {2'h0, s_reg.tm.min};
			3'h2: rd_byte = {3'h0, s_reg.tm.hour};
			3'h3: rd_byte = {5'h00, s_reg.tm.dow};
			3'h4: rd_byte = {3'h0, s_reg.tm.date};
			3'h5: rd_byte = {4'h0, s_reg.tm.month};
			3'h6: rd_byte = {1'b0, s_reg.tm.year};
			default: rd_byte = 8'h00;
		endcase
	end

	always_comb begin
		s_next = s_reg;
		s_next.osc_d = osc_s;
		s_next.scl_d = scl_s;
		s_next.sda_d = sda_s;
		s_next.tick_d = sec_tick;
		s_next.osc_out = !osc_s;
		if (osc_edge) begin
			s_next.pre = s_reg.pre + 15'h0001;
		end
		// counter chain, each field wraps into the next
		if (sec_tick) begin
			s_next.tm.sec = s_reg.tm.sec + 6'h01;
			if (s_reg.tm.sec == SEC_MAX) begin
				s_next.tm.sec = 6'h00;
				s_next.tm.min = s_reg.tm.min + 6'h01;
				if (s_reg.tm.min == MIN_MAX) begin
					s_next.tm.min = 6'h00;
					s_next.tm.hour = s_reg.tm.hour + 5'h01;
					if (s_reg.tm.hour == HOUR_MAX) begin
						s_next.tm.hour = 5'h00;
						s_next.tm.dow = (s_reg.tm.dow == DOW_MAX) ? 3'h0 : s_reg.tm.dow + 3'h1;
						s_next.tm.date = s_reg.tm.date + 5'h01;
						// 2000 to 2099: every fourth year is leap
						if (s_reg.tm.date == days_in(s_reg.tm.month, s_reg.tm.year)) begin
							s_next.tm.date = 5'h01;
							s_next.tm.month = s_reg.tm.month + 4'h1;
							if (s_reg.tm.month == MONTH_MAX) begin
								s_next.tm.month = 4'h1;
								s_next.tm.year = (s_reg.tm.year == YEAR_MAX) ? 7'h00 : s_reg.tm.year + 7'h01;
							end
						end
					end
				end
			end
		end

		// bus slave: one wait cycle, then the access completes
		s_next.wreq = 1'b1;
		if ((avs_req.read || avs_req.write) && s_reg.wreq) begin
			s_next.wreq = 1'b0;
			case (avs_req.address)
				OFS_TIME: s_next.rdata = time_w;
				OFS_DATE: s_next.rdata = date_w;
				OFS_ALM_T: s_next.rdata = s_reg.alm_t;
				OFS_ALM_D: s_next.rdata = {8'h00, s_reg.alm_d};
				OFS_CTRL: s_next.rdata = {24'h000000, s_reg.ctrl};
				OFS_STAT: s_next.rdata = {29'h00000000, bkp_s, s_reg.status};
				OFS_MASK: s_next.rdata = {30'h00000000, s_reg.mask};
				default: s_next.rdata = 32'h00000000;
			endcase
		end
		if (wr_acc) begin
			case (avs_req.address)
				OFS_TIME: begin
					s_next.tm.sec = avs_req.writedata[5:0];
					s_next.tm.min = avs_req.writedata[13:8];
					s_next.tm.hour = avs_req.writedata[20:16];
					s_next.tm.dow = avs_req.writedata[26:24];
					s_next.pre = 15'h0000;
				end
				OFS_DATE: begin
					s_next.tm.date = avs_req.writedata[4:0];
					s_next.tm.month = avs_req.writedata[11:8];
					s_next.tm.year = avs_req.writedata[22:16];
				end
				OFS_ALM_T: s_next.alm_t = avs_req.writedata & ALM_T_MASK;
				OFS_ALM_D: s_next.alm_d = avs_req.writedata[23:0] & ALM_D_MASK;
				OFS_CTRL: s_next.ctrl = avs_req.writedata[7:0];
				OFS_STAT: s_next.status = s_reg.status & ~avs_req.writedata[1:0];
				OFS_MASK: s_next.mask = avs_req.writedata[1:0];
				default: ;
			endcase
		end
		if (rd_acc && avs_req.address == OFS_STAT && s_reg.ctrl[CTL_ACLR]) begin
			s_next.status[ST_ALM] = 1'b0;
		end

		// sets come after clears so an event is never lost
		if (s_reg.pulse != 26'h0000000) begin
			s_next.pulse = s_reg.pulse - 26'h0000001;
		end
		if (alm_hit) begin
			s_next.status[ST_ALM] = 1'b1;
			if (s_reg.ctrl[CTL_IM]) begin
				s_next.pulse = 26'(PULSE_CYCLES);
			end
		end
		if (sec_tick) begin
			s_next.status[ST_SEC] = 1'b1;
		end
		s_next.irq = |(s_next.status & s_next.mask);

		// pin pulls low while oe is high
		if (fo != 4'h0) begin
			s_next.pin_oe = !fo_lvl;
		end else if (s_reg.ctrl[CTL_IM]) begin
			s_next.pin_oe = (s_next.pulse != 26'h0000000);
		end else begin
			s_next.pin_oe = s_next.status[ST_ALM];
		end

		// serial front end: address, register pointer, sequential reads
		if (bkp_s || i2c_stop) begin
			s_next.st = I2C_IDLE;
			s_next.sda_oe = 1'b0;
		end else if (i2c_start) begin
			s_next.st = I2C_ADDR;
			s_next.bitc = 4'h0;
			s_next.sda_oe = 1'b0;
		end else if (scl_rise) begin
			case (s_reg.st)
				I2C_ADDR, I2C_WR: begin
					s_next.sh = {s_reg.sh[6:0], sda_s};
					s_next.bitc = s_reg.bitc + 4'h1;
				end
				I2C_RACK: s_next.st = sda_s ? I2C_IDLE : I2C_ACK;
				default: ;
			endcase
		end else if (scl_fall) begin
			case (s_reg.st)
				I2C_ADDR: if (s_reg.bitc == 4'h8) begin
					s_next.bitc = 4'h0;
					s_next.rw = s_reg.sh[0];
					s_next.sda_oe = (s_reg.sh[7:1] == I2C_DEV_ADDR);
					s_next.st = (s_reg.sh[7:1] == I2C_DEV_ADDR) ? I2C_ACK : I2C_IDLE;
				end
				I2C_WR: if (s_reg.bitc == 4'h8) begin
					s_next.bitc = 4'h0;
					s_next.ptr = s_reg.sh[2:0];
					s_next.sda_oe = 1'b1;
					s_next.st = I2C_ACK;
				end
				I2C_ACK: begin
					s_next.sda_oe = 1'b0;
					s_next.st = I2C_WR;
					s_next.bitc = 4'h0;
					if (s_reg.rw) begin
						s_next.st = I2C_RD;
						s_next.sh = {rd_byte[6:0], 1'b0};
						s_next.sda_oe = !rd_byte[7];
						s_next.bitc = 4'h1;
						s_next.ptr = (s_reg.ptr == 3'h6) ? 3'h0 : s_reg.ptr + 3'h1;
					end
				end
				I2C_RD: if (s_reg.bitc == 4'h8) begin
					s_next.sda_oe = 1'b0;
					s_next.st = I2C_RACK;
				end else begin
					s_next.sda_oe = !s_reg.sh[7];
					s_next.sh = {s_reg.sh[6:0], 1'b0};
					s_next.bitc = s_reg.bitc + 4'h1;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s_reg <= '{tm: '{date: DATE_RST, month: MONTH_RST, default: '0}, wreq: 1'b1, st: I2C_IDLE, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign avs_rsp = '{readdata: s_reg.rdata, waitrequest: s_reg.wreq};
	assign irq = s_reg.irq;
	assign osc_output_pin = s_reg.osc_out;
	assign sda_out = 1'b0;
	assign sda_oe = s_reg.sda_oe;
	assign alarm_or_freq_out_pin_out = 1'b0;
	assign alarm_or_freq_out_pin_oe = s_reg.pin_oe;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sec_carry_a: assert property (
		(sec_tick && !wr_acc && s_reg.tm.sec == SEC_MAX) |=>
		(s_reg.tm.sec == 6'h00 &&
		s_reg.tm.min == (($past(s_reg.tm.min) == MIN_MAX) ? 6'h00 : $past(s_reg.tm.min) + 6'h01)))
		else $error("seconds did not carry into minutes");
	leap_day_a: assert property (
		(sec_tick && !wr_acc && s_reg.tm.month == 4'h2 && s_reg.tm.date == 5'h1c &&
		s_reg.tm.hour == HOUR_MAX && s_reg.tm.min == MIN_MAX && s_reg.tm.sec == SEC_MAX) |=>
		(s_reg.tm.date == ((s_reg.tm.year[1:0] == 2'h0) ? 5'h1d : 5'h01)))
		else $error("february rollover wrong");
	alarm_flag_a: assert property (alm_hit |=> s_reg.status[ST_ALM])
		else $error("alarm match did not set flag");
	irq_level_a: assert property ((s_reg.status[ST_ALM] && s_reg.mask[ST_ALM]) |-> irq)
		else $error("masked-in alarm without interrupt");
	repeat_load_a: assert property ((alm_hit && s_reg.ctrl[CTL_IM]) |=>
		s_reg.pulse == 26'(PULSE_CYCLES))
		else $error("pulsed alarm did not retrigger");
	freq_follow_a: assert property ((fo == 4'h1 && osc_s) |=> !alarm_or_freq_out_pin_oe)
		else $error("frequency output not following clock");
	backup_quiet_a: assert property (bkp_s |=> !sda_oe)
		else $error("data line pulled in backup mode");
	addr_ack_a: assert property ((scl_fall && s_reg.st == I2C_ADDR && s_reg.bitc == 4'h8 &&
		s_reg.sh[7:1] == I2C_DEV_ADDR) |=> sda_oe)
		else $error("own address not acknowledged");
	single_hold_a: assert property ((fo == 4'h0 && !s_reg.ctrl[CTL_IM] && $stable(s_reg.ctrl) && s_reg.status[ST_ALM]) |->
		alarm_or_freq_out_pin_oe)
		else $error("single-event pin released while flag set");
	pulse_low_a: assert property (($rose(alarm_or_freq_out_pin_oe) && fo == 4'h0 && s_reg.ctrl[CTL_IM] &&
		$stable(s_reg.ctrl)) |-> alarm_or_freq_out_pin_oe [*8])
		else $error("alarm pulse too short");
	// pin follows only the selected clock level (raw reference or divider bit), and the flag stays quiet
	freq_no_alarm_a: assert property ((fo != 4'h0 && $stable(fo)) |->
		(alarm_or_freq_out_pin_oe == !$past(fo_lvl) && !$rose(s_reg.status[ST_ALM])))
		else $error("alarm active in frequency mode");

	alarm_fire_c: cover property (alm_hit);
	leap_day_c: cover property (sec_tick && s_reg.tm.month == 4'h2 && s_reg.tm.date == 5'h1c && s_reg.tm.year[1:0] == 2'h0);
	serial_read_c: cover property (s_reg.st == I2C_RD && scl_fall);
	bus_write_c: cover property (wr_acc && avs_req.address == OFS_CTRL);
endmodule // rtc_core
`default_nettype wire

// File: rtc_i2c_host.sv
/*
 Two-wire bus master model standing in for the host processor.
 Assumes the bench calls its tasks right after a rising sys_clk edge.
*/
`timescale 1ns/100ps
`default_nettype none
module rtc_i2c_host #(
	parameter int QTR = 160
) (
	// clock
	input wire logic sys_clk,
	// device pull-down and bus levels
	input wire logic dev_sda_oe,
	output logic scl,
	output logic sda
);
	logic pull_low;

	// wired-and of both pull-downs over the pull-up
	assign sda = !(pull_low || dev_sda_oe);

	initial begin
		scl = 1'b1;
		pull_low = 1'b0;
	end

	// quarter bit of 640 ns keeps scl below 400 kHz
	task automatic qtr();
		repeat (QTR) @(posedge sys_clk);
	endtask

	task automatic start();
		pull_low <= 1'b1;
		qtr();
		scl <= 1'b0;
		qtr();
	endtask

	task automatic stop();
		pull_low <= 1'b1;
		qtr();
		scl <= 1'b1;
		qtr();
		pull_low <= 1'b0;
		qtr();
	endtask

	// data moves only while scl is low, sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		pull_low <= !b;
		qtr();
		scl <= 1'b1;
		qtr();
		r = sda;
		qtr();
		scl <= 1'b0;
		qtr();
	endtask

	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask

	task automatic read_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule // rtc_i2c_host
`default_nettype wire

// File: rtc_core_tb_top.sv
/*
 Self-checking bench for the clock core: register bus, alarm, shared pin,
 calendar rollover and serial reads. Assumes the host model file beside it.
*/
`timescale 1ns/100ps
`default_nettype none
module rtc_core_tb_top;
	import rtc_pkg::*;
	logic sys_clk, reset, irq, osc, scl, sda, sda_oe, backup, pin_out, pin_oe, ack, osc_out, sda_dout;
	rtc_avs_req_s req;
	rtc_avs_rsp_s rsp;
	logic [1:0] oc;
	logic [31:0] rd;
	logic [7:0] byte_v;
	int miscompares, n_checks, ones;

	rtc_core #(.PULSE_CYCLES(20)) u_rtc_core (.sys_clk(sys_clk), .reset(reset), .avs_req(req),
		.avs_rsp(rsp), .irq(irq), .osc_input_pin(osc), .osc_output_pin(osc_out), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_dout), .sda_oe(sda_oe), .backup_mode(backup),
		.alarm_or_freq_out_pin_out(pin_out), .alarm_or_freq_out_pin_oe(pin_oe));
	rtc_i2c_host u_rtc_i2c_host (.sys_clk(sys_clk), .dev_sda_oe(sda_oe), .scl(scl), .sda(sda));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// reference of three sys clocks keeps one second under 100k cycles
	always @(posedge sys_clk) begin
		oc <= (oc == 2'h2) ? 2'h0 : oc + 2'h1;
		osc <= (oc != 2'h0);
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
		int n;
		logic late;
		n = 0;
		req.address <= a;
		req.writedata <= wd;
		req.write <= wr;
		req.read <= !wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (rsp.waitrequest !== 1'b0 && n < 64);
		// a request still pending here ran out of its bound
		late = (rsp.waitrequest !== 1'b0);
		rd = rsp.readdata;
		req.write <= 1'b0;
		req.read <= 1'b0;
		@(posedge sys_clk);
		if (late) begin
			chk(32'h0, 32'h1, "bus timeout");
			end_sim();
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [4:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0);
		chk(rd, exp, what);
	endtask

	initial begin
		reset = 1'b1;
		req = '0;
		osc = 1'b0;
		oc = 2'h0;
		backup = 1'b0;
		miscompares = 0;
		n_checks = 0;
		cyc(16);
		reset <= 1'b0;
		cyc(1);
		rdchk(OFS_TIME, 32'h0, "time at reset");
		rdchk(OFS_DATE, 32'h0000_0101, "date at reset");
		rdchk(5'h1c, 32'h0, "unmapped read");
		wr(OFS_ALM_T, 32'hffff_ffff);
		rdchk(OFS_ALM_T, ALM_T_MASK, "alarm time fields");
		wr(OFS_ALM_T, 32'h0);
		// amplifier output is the inverted reference, high one cycle in three
		ones = 0;
		repeat (12) begin
			@(posedge sys_clk);
			ones += (osc_out === 1'b1) ? 1 : 0;
		end
		chk(32'(ones), 32'h4, "oscillator output duty");
		$display("test registers done");
		for (int s = 1; s <= 3; s++) begin
			wr(OFS_CTRL, 32'(s) << 4);
			cyc(4);
			ones = 0;
			repeat (12) begin
				@(posedge sys_clk);
				ones += (pin_oe === 1'b1) ? 1 : 0;
			end
			chk(32'(ones), (s == 1) ? 32'h4 : 32'h6, "freq pin duty");
			chk({30'h0, sda_dout, pin_out}, 32'h0, "pins drive low only");
		end
		wr(OFS_CTRL, 32'h0);
		$display("test frequency done");
		// alarm on the 29th, single event with auto-clear
		wr(OFS_ALM_D, 32'h0000_009d);
		wr(OFS_MASK, 32'h1);
		wr(OFS_CTRL, 32'h5);
		wr(OFS_DATE, 32'h0000_021c);
		wr(OFS_TIME, 32'h0617_3b3b);
		backup <= 1'b1;
		cyc(4);
		rdchk(OFS_STAT, 32'h4, "backup status");
		u_rtc_i2c_host.start();
		u_rtc_i2c_host.write_byte({I2C_DEV_ADDR, 1'b1}, ack);
		chk({31'h0, ack}, 32'h0, "ack in backup");
		u_rtc_i2c_host.stop();
		backup <= 1'b0;
		cyc(4);
		u_rtc_i2c_host.start();
		u_rtc_i2c_host.write_byte({I2C_DEV_ADDR, 1'b1}, ack);
		chk({31'h0, ack}, 32'h1, "address ack");
		u_rtc_i2c_host.read_byte(1'b1, byte_v);
		chk({24'h0, byte_v}, 32'h3b, "serial seconds");
		u_rtc_i2c_host.stop();
		$display("test serial done");
		ones = 0;
		while (irq !== 1'b1 && ones < 120000) begin
			cyc(1);
			ones++;
		end
		if (irq !== 1'b1) begin
			chk(32'h0, 32'h1, "alarm never came");
			end_sim();
		end
		chk({31'h0, pin_oe}, 32'h1, "pin held low");
		rdchk(OFS_TIME, 32'h0, "midnight rollover");
		rdchk(OFS_DATE, 32'h0000_021d, "leap day");
		rdchk(OFS_STAT, 32'h3, "alarm flag");
		rdchk(OFS_STAT, 32'h2, "flag auto cleared");
		cyc(2);
		chk({30'h0, irq, pin_oe}, 32'h0, "irq and pin released");
		wr(OFS_MASK, 32'h2);
		cyc(2);
		chk({31'h0, irq}, 32'h1, "tick unmasked");
		wr(OFS_STAT, 32'h2);
		cyc(2);
		chk({31'h0, irq}, 32'h0, "tick cleared");
		$display("test alarm done");
		end_sim();
	end
endmodule // rtc_core_tb_top
`default_nettype wire
